/* gated_interval_width_counter_defines.vh */
// Function
// - The counter is 24 bits wide, bounding the longest measurable interval.
// - At all ones the counter wraps to zero, keeps counting, latches rollover flag.
// - Count source is fast timebase by default, slow timebase, or a connector pin.
// - Source active edge is selectable; falling edges instead of default rising.
// - Gate may be taken from any connector pin instead of the dedicated one.
// - Period mode with active-low gate times falling edge to next falling edge.
// - Count source may be the peer counter's terminal count, cascading both counters.
// - One-shot width mode by default counts fast timebase from gate rise to fall.
// - Every measurement starts from zero and counts upward.
// - Armed status stays high during a measurement and drops when it completes.
// - Width mode with active-low gate measures gate fall to next gate rise.
// - Gate active at arm in one-shot width mode raises an error flag.
// - Triggered width with active-high gate counts only after a falling gate edge.
// - Triggered width with active-low gate needs a rising gate edge first.
// - Counter zero and counter one default to their own dedicated gate pins.
// - Period mode by default times rising to rising gate edges on fast timebase.
// - A halt action stops any operation at any time.
`ifndef GATED_INTERVAL_WIDTH_COUNTER_DEFINES_VH
`define GATED_INTERVAL_WIDTH_COUNTER_DEFINES_VH

`define CTR_WIDTH 24
`define PIN_COUNT 10
`define PIN_IDX_W 4

`define OFF_ACTION 12'h000
`define OFF_CONFIG 12'h004
`define OFF_STATUS 12'h008
`define OFF_COUNT 12'h00c

`define ACT_ARM 0
`define ACT_HALT 1
`define ACT_PRELOAD 2

`define CFG_MODE_LO 0
`define CFG_MODE_HI 1
`define CFG_SRC_LO 2
`define CFG_SRC_HI 3
`define CFG_SRC_EDGE 4
`define CFG_SRC_PIN_LO 5
`define CFG_SRC_PIN_HI 8
`define CFG_GATE_POL 9
`define CFG_GATE_PIN_LO 10
`define CFG_GATE_PIN_HI 13
`define CFG_GATE_CUSTOM 14
`define CFG_BITS 15
`define CFG_RESET 15'h0000

`define MODE_PERIOD 2'h0
`define MODE_ONE_SHOT_WIDTH 2'h1
`define MODE_TRIG_WIDTH 2'h2

`define SRC_FAST 2'h0
`define SRC_SLOW 2'h1
`define SRC_PIN 2'h2
`define SRC_PEER 2'h3

`define STS_ARMED 0
`define STS_ROLLOVER 1
`define STS_ERROR 2

`define CTR_ZERO_GATE_PIN 4'h9
`define CTR_ONE_GATE_PIN 4'h4

`endif

/* signal_edge_detect.v */
module signal_edge_detect #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);
  reg [WIDTH-1:0] last;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      always @(posedge clk)
      begin
        if (!rst_n)
          last[i] <= 1'b0;
        else
          last[i] <= level[i];
      end
      assign rise[i] = level[i] & ~last[i];
      assign fall[i] = ~level[i] & last[i];
    end
  endgenerate
endmodule

/* gated_interval_width_counter.v */
// Chosen here: the APB register port and the register addresses.
`include "gated_interval_width_counter_defines.vh"

module gated_interval_width_counter #(
  parameter COUNTER_ID = 0,
  parameter CTR_W = `CTR_WIDTH,
  parameter PINS = `PIN_COUNT
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire fast_internal_timebase,
  input wire slow_internal_timebase,
  input wire peer_terminal_count,
  input wire [PINS-1:0] connector_pins,
  output reg armed_status,
  output reg rollover_flag,
  output reg arm_error,
  output reg [CTR_W-1:0] captured_count
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_TRIG = 4'b0010;
  localparam ST_START = 4'b0100;
  localparam ST_COUNT = 4'b1000;

  reg [`CFG_BITS-1:0] cfg_shadow;
  reg [`CFG_BITS-1:0] cfg_active;
  reg [3:0] state;
  reg [3:0] next_state;
  reg [CTR_W-1:0] next_count;
  reg next_rollover;
  reg next_armed;
  reg next_error;
  reg [`CFG_BITS-1:0] next_cfg_active;
  reg src_level;
  reg [31:0] rd_word;
  reg rd_ok;
  reg cfg_settle;

  wire bus_done = psel & penable & pready;
  wire wr_en = bus_done & pwrite & ~pslverr;
  wire act_arm = wr_en && paddr == `OFF_ACTION && pwdata[`ACT_ARM];
  wire act_halt = wr_en && paddr == `OFF_ACTION && pwdata[`ACT_HALT];
  wire act_preload = wr_en && paddr == `OFF_ACTION && pwdata[`ACT_PRELOAD];

  wire [1:0] mode = cfg_active[`CFG_MODE_HI:`CFG_MODE_LO];
  wire [1:0] src_sel = cfg_active[`CFG_SRC_HI:`CFG_SRC_LO];
  wire src_falling = cfg_active[`CFG_SRC_EDGE];
  wire [`PIN_IDX_W-1:0] src_pin = cfg_active[`CFG_SRC_PIN_HI:`CFG_SRC_PIN_LO];
  wire gate_low = cfg_active[`CFG_GATE_POL];
  wire [`PIN_IDX_W-1:0] custom_gate_pin = cfg_active[`CFG_GATE_PIN_HI:`CFG_GATE_PIN_LO];
  wire [`PIN_IDX_W-1:0] default_gate_pin = (COUNTER_ID == 0) ? `CTR_ZERO_GATE_PIN : `CTR_ONE_GATE_PIN;
  wire [`PIN_IDX_W-1:0] gate_pin = cfg_active[`CFG_GATE_CUSTOM] ? custom_gate_pin : default_gate_pin;

  // Out-of-range pin indices read as low so a bad index never counts.
  wire gate_raw = (gate_pin < PINS) ? connector_pins[gate_pin] : 1'b0;
  wire src_pin_raw = (src_pin < PINS) ? connector_pins[src_pin] : 1'b0;

  wire gate_active = gate_raw ^ gate_low;

  // The arm check uses the configuration being loaded, not the old one.
  wire [1:0] new_mode = cfg_shadow[`CFG_MODE_HI:`CFG_MODE_LO];
  wire new_gate_low = cfg_shadow[`CFG_GATE_POL];
  wire [`PIN_IDX_W-1:0] new_gate_pin = cfg_shadow[`CFG_GATE_CUSTOM] ?
    cfg_shadow[`CFG_GATE_PIN_HI:`CFG_GATE_PIN_LO] : default_gate_pin;
  wire new_gate_raw = (new_gate_pin < PINS) ? connector_pins[new_gate_pin] : 1'b0;
  wire new_gate_active = new_gate_raw ^ new_gate_low;

  always @*
  begin
    case (src_sel)
      `SRC_FAST: src_level = fast_internal_timebase;
      `SRC_SLOW: src_level = slow_internal_timebase;
      `SRC_PIN: src_level = src_pin_raw;
      `SRC_PEER: src_level = peer_terminal_count;
      default: src_level = fast_internal_timebase;
    endcase
  end

  wire [1:0] edge_rise;
  wire [1:0] edge_fall;

  signal_edge_detect #(
    .WIDTH(2)
  ) u_edges (
    .clk(clk),
    .rst_n(rst_n),
    .level({gate_active, src_level}),
    .rise(edge_rise),
    .fall(edge_fall)
  );

  reg src_tick;
  reg gate_on;
  reg gate_off;

  // A new source or gate selection makes the detector compare two different
  // signals for one cycle, so edges seen in that cycle are dropped.
  // A real edge that lands in exactly that cycle is lost as well.
  always @*
  begin
    src_tick = 1'b0;
    gate_on = 1'b0;
    gate_off = 1'b0;
    if (!cfg_settle)
    begin
      src_tick = src_falling ? edge_fall[0] : edge_rise[0];
      gate_on = edge_rise[1];
      gate_off = edge_fall[1];
    end
  end

  wire is_period = (mode == `MODE_PERIOD);
  // period ends on next active edge
  wire meas_end = is_period ? gate_on : gate_off;
  wire [CTR_W-1:0] all_ones = {CTR_W{1'b1}};

  always @*
  begin
    next_state = state;
    next_count = captured_count;
    next_rollover = rollover_flag;
    next_armed = armed_status;
    next_error = arm_error;
    next_cfg_active = cfg_active;
    if (act_preload)
      next_cfg_active = cfg_shadow;
    case (state)
      ST_IDLE:
      begin
        if (act_arm)
        begin
          next_cfg_active = cfg_shadow;
          next_count = {CTR_W{1'b0}};
          next_rollover = 1'b0;
          next_error = 1'b0;
          if (new_mode == `MODE_ONE_SHOT_WIDTH && new_gate_active)
          begin
            next_error = 1'b1;
            next_armed = 1'b0;
          end
          else if (new_mode == `MODE_TRIG_WIDTH)
          begin
            next_state = ST_TRIG;
            next_armed = 1'b1;
          end
          else
          begin
            next_state = ST_START;
            next_armed = 1'b1;
          end
        end
      end
      ST_TRIG:
      begin
        if (gate_off)
          next_state = ST_START;
      end
      ST_START:
      begin
        if (gate_on)
          next_state = ST_COUNT;
      end
      ST_COUNT:
      begin
        if (meas_end)
        begin
          next_state = ST_IDLE;
          next_armed = 1'b0;
        end
        else if (src_tick && (is_period || gate_active))
        begin
          next_count = captured_count + {{(CTR_W-1){1'b0}}, 1'b1};
          if (captured_count == all_ones)
            next_rollover = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_armed = 1'b0;
      end
    endcase
    if (act_halt)
    begin
      next_state = ST_IDLE;
      next_armed = 1'b0;
      next_count = {CTR_W{1'b0}};
      next_rollover = 1'b0;
      next_error = 1'b0;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      captured_count <= {CTR_W{1'b0}};
      rollover_flag <= 1'b0;
      armed_status <= 1'b0;
      arm_error <= 1'b0;
      cfg_active <= `CFG_RESET;
    end
    else
    begin
      state <= next_state;
      captured_count <= next_count;
      rollover_flag <= next_rollover;
      armed_status <= next_armed;
      arm_error <= next_error;
      cfg_active <= next_cfg_active;
    end
  end

  // Reset masks the first cycle too, since the detector restarts from low levels.
  always @(posedge clk)
  begin
    if (!rst_n)
      cfg_settle <= 1'b1;
    else
      cfg_settle <= (next_cfg_active != cfg_active);
  end

  always @*
  begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (paddr)
      `OFF_ACTION: rd_word = 32'h00000000;
      `OFF_CONFIG: rd_word = {{(32-`CFG_BITS){1'b0}}, cfg_shadow};
      `OFF_STATUS: rd_word = {29'h00000000, arm_error, rollover_flag, armed_status};
      `OFF_COUNT: rd_word = {{(32-CTR_W){1'b0}}, captured_count};
      default: rd_ok = 1'b0;
    endcase
  end

  // Every access waits one extra cycle so the answer comes from flip-flops.
  wire access_cycle = psel & penable & ~pready;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= access_cycle;
      if (access_cycle)
      begin
        pslverr <= ~rd_ok;
        prdata <= (pwrite | ~rd_ok) ? 32'h00000000 : rd_word;
      end
      else
      begin
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
      end
    end
  end

  // The shadow feeds only the next arm or preload; a preload applies it even to a running measurement.
  always @(posedge clk)
  begin
    if (!rst_n)
      cfg_shadow <= `CFG_RESET;
    else if (wr_en && paddr == `OFF_CONFIG)
      cfg_shadow <= pwdata[`CFG_BITS-1:0];
  end
endmodule

/* interval_chk.sv */
module interval_chk #(
  parameter CTR_W = 24
) (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire armed_status,
  input wire rollover_flag,
  input wire arm_error,
  input wire [CTR_W-1:0] captured_count
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  a_error_unarmed: assert property (arm_error |-> !armed_status)
    else $error("armed despite arm error");
  a_start_zero: assert property ($rose(armed_status) |-> captured_count == 0 && !rollover_flag)
    else $error("measurement not started from zero");
  a_count_step: assert property (armed_status ##1 armed_status |->
    captured_count == $past(captured_count) || captured_count == $past(captured_count) + 1'b1)
    else $error("count moved by more than one");
  a_idle_hold: assert property (!armed_status && !(psel && penable) ##1 !armed_status |->
    $stable(captured_count))
    else $error("count changed while idle");
  a_wrap_flag: assert property (armed_status && captured_count == 0 &&
    $past(captured_count) == {CTR_W{1'b1}} |-> ##[0:1] rollover_flag)
    else $error("wrap without rollover flag");
endmodule

/* far_side.sv */
module far_side (
  input wire clk,
  output logic fast_tb = 1'b0,
  output logic slow_tb = 1'b0,
  output logic peer_tc = 1'b0,
  output logic [9:0] pins = 10'h000
);
  timeunit 1ns;
  timeprecision 1ns;
  // Timebases stand still between pulses so counts are exact.
  task automatic drive(input logic [1:0] src, input logic v);
    @(posedge clk);
    case (src)
      2'h0: fast_tb <= v;
      2'h1: slow_tb <= v;
      2'h2: pins[3] <= v;
      default: peer_tc <= v;
    endcase
    @(posedge clk);
  endtask
  task automatic pulse(input logic [1:0] src, input int n);
    repeat (n)
    begin
      drive(src, 1'b1);
      drive(src, 1'b0);
    end
  endtask
  task automatic gate(input logic [3:0] pin, input logic v);
    @(posedge clk);
    pins[pin] <= v;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CTR_W = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, fast_tb, slow_tb, peer_tc, armed_status, rollover_flag, arm_error;
  wire [9:0] pins;
  wire [CTR_W-1:0] captured_count;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic er;
  logic [14:0] rows [7] = '{15'h0000, 15'h4a14, 15'h0001, 15'h5669, 15'h000d, 15'h0002, 15'h0216};
  gated_interval_width_counter #(.COUNTER_ID(0), .CTR_W(CTR_W), .PINS(10)) gated_interval_width_counter_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fast_internal_timebase(fast_tb),
    .slow_internal_timebase(slow_tb), .peer_terminal_count(peer_tc), .connector_pins(pins),
    .armed_status(armed_status), .rollover_flag(rollover_flag), .arm_error(arm_error),
    .captured_count(captured_count));
  far_side far_side_i (.clk(clk), .fast_tb(fast_tb), .slow_tb(slow_tb), .peer_tc(peer_tc), .pins(pins));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1)
      n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic measure(input logic [14:0] cfg, input int n);
    logic [3:0] gp;
    gp = cfg[14] ? cfg[13:10] : 4'h9;
    far_side_i.gate(gp, cfg[9]);
    apb(1'b1, 12'h004, {17'h0, cfg});
    apb(1'b1, 12'h000, 32'h1);
    if (cfg[1:0] == 2'h2)
    begin
      far_side_i.gate(gp, !cfg[9]);
      far_side_i.pulse(cfg[3:2], 2);
      far_side_i.gate(gp, cfg[9]);
    end
    // Armed is looked at away from the edge that sets it.
    @(negedge clk);
    chk("armed", 32'h1, {31'h0, armed_status});
    far_side_i.gate(gp, !cfg[9]);
    far_side_i.pulse(cfg[3:2], n);
    far_side_i.gate(gp, cfg[9]);
    if (cfg[1:0] == 2'h0)
      far_side_i.gate(gp, !cfg[9]);
    far_side_i.pulse(cfg[3:2], 2);
    apb(1'b0, 12'h00c, 32'h0);
    chk("count", n, rd);
    chk("armed", 32'h0, {31'h0, armed_status});
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #1000000;
    n_mismatch++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("config", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("pslverr", 32'h1, {31'h0, er});
    $display("reset test done");
    for (int i = 0; i < 7; i++)
    begin
      measure(rows[i], i + 2);
      $display("row %0d done", i);
    end
    // Wrap of the shortened counter.
    apb(1'b1, 12'h004, 32'h1);
    far_side_i.gate(4'h9, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    far_side_i.gate(4'h9, 1'b1);
    far_side_i.pulse(2'h0, 17);
    far_side_i.gate(4'h9, 1'b0);
    apb(1'b0, 12'h00c, 32'h0);
    chk("wrapped count", 32'h1, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("rollover status", 32'h2, rd);
    $display("rollover test done");
    // The gate is left active on purpose here.
    far_side_i.gate(4'h9, 1'b1);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("error status", 32'h4, rd);
    far_side_i.gate(4'h9, 1'b0);
    $display("arm error test done");
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h000, 32'h1);
    far_side_i.gate(4'h9, 1'b1);
    far_side_i.pulse(2'h0, 3);
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    chk("halted count", 32'h0, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("halted status", 32'h0, rd);
    $display("halt test done");
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h008, 32'h0);
    chk("arm with halt status", 32'h0, rd);
    $display("arm with halt test done");
    // A reset in mid-measurement must clear counter, flags and settings.
    apb(1'b1, 12'h004, 32'h10);
    far_side_i.gate(4'h9, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    far_side_i.gate(4'h9, 1'b1);
    far_side_i.pulse(2'h0, 2);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h00c, 32'h0);
    chk("count after reset", 32'h0, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("status after reset", 32'h0, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("config after reset", 32'h0, rd);
    $display("mid-run reset test done");
    report_and_stop;
  end
endmodule
bind gated_interval_width_counter interval_chk #(.CTR_W(CTR_W)) interval_chk_i (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .armed_status(armed_status), .rollover_flag(rollover_flag), .arm_error(arm_error),
  .captured_count(captured_count));
